// *** logic/svrw_pkg.sv ***
/*
 * Constants for the supervisor, reset pulse and watchdog block.
 * Assumes a 10 MHz system clock and digital indications from the analog comparators.
 */
// What this block does
// RULE1: Low manual request starts a reset pulse.
// RULE2: Manual request is debounced into one episode.
// RULE3: Unconnected manual request reads as no reset.
// RULE4: Power-fail flag low while sense below reference.
// RULE5: Board ties unused power-fail sense to rail.
// RULE6: Steady kick beyond timeout drives expired low.
// RULE7: Each kick edge clears counter; host toggles.
// RULE8: Counter held cleared while reset asserted.
// RULE9: Floating kick input disables the watchdog.
// RULE10: Reset pulse lasts 200 ms when triggered.
// RULE11: Reset held throughout undervoltage.
// RULE12: Reset held 200 ms after cause clears.
// RULE13: Watchdog timeout alone never asserts reset.
// RULE14: Expired stays low until counter cleared.
// RULE15: Expired forced low during undervoltage.
// RULE16: Active-high reset is complement of reset.
// RULE17: Watchdog timeout is nominally 1.6 seconds.
// RULE18: Watchdog timing starts after reset releases.
// RULE19: Intervals come from parameterised clock counters.
// RULE20: Asynchronous inputs synchronised before use.
package svrw_pkg;
    localparam int unsigned CLK_HZ           = 10_000_000;
    localparam int unsigned RESET_PULSE_MS   = 200;
    localparam int unsigned WD_TIMEOUT_MS    = 1600;
    localparam int unsigned RESET_PULSE_CYC  = RESET_PULSE_MS * (CLK_HZ / 1000);
    localparam int unsigned WD_TIMEOUT_CYC   = WD_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int unsigned SYNC_STAGES      = 3;
    localparam logic        RESET_ACTIVE_N   = 1'b0;

    typedef enum logic [1:0] {
        SVRW_IDLE  = 2'b00,
        SVRW_HOLD  = 2'b01,
        SVRW_PULSE = 2'b10
    } svrw_state_t;
endpackage : svrw_pkg

// *** logic/svrw_sync.sv ***
/*
 * Three-stage synchroniser; a change is accepted when stages two and three agree.
 * Assumes an asynchronous input and the system clock domain.
 */
`timescale 1ns/100ps
module svrw_sync
    import svrw_pkg::*;
#(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic reset_n,
    // Data
    input  wire logic async_in,
    output logic      sync_out
);
    logic [SYNC_STAGES-1:0] stage_r;
    logic [SYNC_STAGES-1:0] stage_nxt;
    logic                   out_r;
    logic                   out_nxt;

    // =========================================================
    // Shift chain
    always_comb begin
        stage_nxt = {stage_r[SYNC_STAGES-2:0], async_in};
        out_nxt   = out_r;
        if (stage_r[1] == stage_r[2]) begin // see RULE20
            out_nxt = stage_r[2];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            stage_r <= {SYNC_STAGES{RESET_VAL}};
            out_r   <= RESET_VAL;
        end else begin
            stage_r <= stage_nxt;
            out_r   <= out_nxt;
        end
    end

    assign sync_out = out_r;
endmodule : svrw_sync

// *** logic/svrw_top.sv ***
/*
 * Supervisor: reset pulse generator, watchdog timer and power-fail flag.
 * Assumes comparators deliver digital levels and the kick input's third
 * level arrives as a separate floating indication.
 */
`timescale 1ns/100ps
module svrw_top
    import svrw_pkg::*;
#(
    parameter int unsigned RESET_CYCLES = RESET_PULSE_CYC, // see RULE19
    parameter int unsigned WD_CYCLES    = WD_TIMEOUT_CYC   // see RULE19
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic reset_n,
    // Supply and comparator indications
    input  wire logic undervoltage,
    input  wire logic power_fail_sense,
    // Manual reset request
    input  wire logic manual_reset_request_n,
    // Watchdog kick, level and floating indication
    input  wire logic watchdog_kick,
    input  wire logic watchdog_kick_float,
    // Outputs to the host
    output logic      reset_out_n,
    output logic      reset_out,
    output logic      watchdog_expired_n,
    output logic      power_fail_flag_n
);
    // =========================================================
    // Counter widths and end points
    localparam int            RW       = $clog2(RESET_CYCLES + 1);
    localparam int            WW       = $clog2(WD_CYCLES + 1);
    localparam logic [RW-1:0] RST_LAST = RW'(RESET_CYCLES - 1);
    localparam logic [WW-1:0] WD_LAST  = WW'(WD_CYCLES - 1);

    // =========================================================
    // Synchronised inputs
    logic uv_s;
    logic pf_s;
    logic mr_s;
    logic kick_s;
    logic float_s;

    // =========================================================
    // Input synchronisers
    // Undervoltage reads as present until the chain fills: power-on reset
    svrw_sync #(
        .RESET_VAL (1'b1)
    ) u_uv (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in (undervoltage),
        .sync_out (uv_s)
    ); // see RULE20

    svrw_sync #(
        .RESET_VAL (1'b1)
    ) u_pf (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in (power_fail_sense),
        .sync_out (pf_s)
    ); // see RULE20

    // Idle level high: an open request line asks for nothing
    svrw_sync #(
        .RESET_VAL (1'b1)
    ) u_mr (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in (manual_reset_request_n),
        .sync_out (mr_s)
    ); // see RULE3

    svrw_sync #(
        .RESET_VAL (1'b0)
    ) u_kick (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in (watchdog_kick),
        .sync_out (kick_s)
    ); // see RULE20

    // Reads as floating until the chain fills, so no timing starts early
    svrw_sync #(
        .RESET_VAL (1'b1)
    ) u_float (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in (watchdog_kick_float),
        .sync_out (float_s)
    ); // see RULE9

    // =========================================================
    // Reset pulse generator
    svrw_state_t   st_r;
    svrw_state_t   st_nxt;
    logic [RW-1:0] rcnt_r;
    logic [RW-1:0] rcnt_nxt;
    logic          rst_n_r;
    logic          rst_n_nxt;
    logic          rst_r;
    logic          rst_nxt;

    always_comb begin
        st_nxt    = st_r;
        rcnt_nxt  = rcnt_r;
        unique case (st_r)
            SVRW_IDLE: begin
                if (uv_s || !mr_s) begin // see RULE1
                    st_nxt = SVRW_HOLD;
                end
            end
            SVRW_HOLD: begin
                rcnt_nxt = '0;
                if (!uv_s && mr_s) begin // see RULE11
                    st_nxt = SVRW_PULSE;
                end
            end
            SVRW_PULSE: begin
                // Bounces restart the interval, giving one clean episode
                if (uv_s || !mr_s) begin // see RULE2
                    st_nxt = SVRW_HOLD;
                end else if (rcnt_r == RST_LAST) begin // see RULE12
                    st_nxt = SVRW_IDLE;
                end else begin
                    rcnt_nxt = rcnt_r + 1'b1; // see RULE10
                end
            end
            default: st_nxt = SVRW_HOLD;
        endcase
        rst_n_nxt = (st_nxt == SVRW_IDLE);
        rst_nxt   = !rst_n_nxt; // see RULE16
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st_r    <= SVRW_HOLD;
            rcnt_r  <= '0;
            rst_n_r <= RESET_ACTIVE_N;
            rst_r   <= ~RESET_ACTIVE_N;
        end else begin
            st_r    <= st_nxt;
            rcnt_r  <= rcnt_nxt;
            rst_n_r <= rst_n_nxt;
            rst_r   <= rst_nxt;
        end
    end

    // =========================================================
    // Watchdog timer; timeout only drives the expired flag
    logic [WW-1:0] wcnt_r;
    logic [WW-1:0] wcnt_nxt;
    logic          kick_d_r;
    logic          kick_d_nxt;
    logic          exp_r;
    logic          exp_nxt;

    always_comb begin
        kick_d_nxt = kick_s;
        wcnt_nxt   = wcnt_r;
        exp_nxt    = exp_r;
        if (!rst_n_r || float_s || (kick_s != kick_d_r)) begin // see RULE7
            // Cleared during reset, while floating and on any edge
            wcnt_nxt = '0; // see RULE8
            exp_nxt  = 1'b0; // see RULE14
        end else if (wcnt_r == WD_LAST) begin // see RULE17
            exp_nxt = 1'b1; // see RULE6
        end else begin
            wcnt_nxt = wcnt_r + 1'b1; // see RULE18
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wcnt_r   <= '0;
            kick_d_r <= 1'b0;
            exp_r    <= 1'b0;
        end else begin
            wcnt_r   <= wcnt_nxt;
            kick_d_r <= kick_d_nxt;
            exp_r    <= exp_nxt;
        end
    end

    // =========================================================
    // Expired flag; undervoltage overrides the timer state
    logic wdo_r;
    logic wdo_nxt;

    always_comb begin
        wdo_nxt = !(exp_nxt && !float_s) && !uv_s; // see RULE15
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wdo_r <= 1'b0;
        end else begin
            wdo_r <= wdo_nxt;
        end
    end

    // =========================================================
    // Power-fail flag; follows the comparator after synchronising
    logic pfo_r;
    logic pfo_nxt;

    always_comb begin
        pfo_nxt = pf_s; // see RULE4
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pfo_r <= 1'b1;
        end else begin
            pfo_r <= pfo_nxt;
        end
    end

    // =========================================================
    // Outputs, each straight from its register
    // Reset follows only undervoltage and manual request, never the timer
    assign reset_out_n        = rst_n_r; // see RULE13
    assign reset_out          = rst_r;
    assign watchdog_expired_n = wdo_r;
    assign power_fail_flag_n  = pfo_r;
endmodule : svrw_top

// *** sim/svrw_asserts.sv ***
/* Checker bound into svrw_top.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/100ps
module svrw_asserts #(
    parameter int unsigned RESET_CYCLES = 20,
    parameter int unsigned WD_CYCLES    = 50
) (
    // Clock, reset and inputs
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic undervoltage,
    input wire logic power_fail_sense,
    input wire logic manual_reset_request_n,
    input wire logic watchdog_kick_float,
    // Outputs
    input wire logic reset_out_n,
    input wire logic reset_out,
    input wire logic watchdog_expired_n,
    input wire logic power_fail_flag_n
);
    // ========
    // Checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic [31:0] low_r;
    always_ff @(posedge sys_clk) low_r <= (reset_out_n || !reset_n) ? '0 : low_r + 1;
    property p_cmp; reset_out == !reset_out_n; endproperty
    a_cmp: assert property (p_cmp) else $error("cmp");
    property p_uv; undervoltage |-> ##[1:6] !reset_out_n; endproperty
    a_uv: assert property (p_uv) else $error("uv");
    property p_mr; !manual_reset_request_n |-> ##[1:6] !reset_out_n; endproperty
    a_mr: assert property (p_mr) else $error("mr");
    property p_uvw; undervoltage |-> ##[1:6] !watchdog_expired_n; endproperty
    a_uvw: assert property (p_uvw) else $error("uvw");
    property p_pf; power_fail_sense [*8] |-> power_fail_flag_n; endproperty
    a_pf: assert property (p_pf) else $error("pf");
    property p_wd; (manual_reset_request_n && !undervoltage) [*8] ##0 reset_out_n
        |=> reset_out_n; endproperty
    a_wd: assert property (p_wd) else $error("wd");
    property p_len; $rose(reset_out_n) |-> low_r >= RESET_CYCLES; endproperty
    a_len: assert property (p_len) else $error("len");
    property p_flt; (watchdog_kick_float && !undervoltage) [*8] |-> watchdog_expired_n; endproperty
    a_flt: assert property (p_flt) else $error("flt");
endmodule : svrw_asserts
bind svrw_top svrw_asserts #(.RESET_CYCLES(RESET_CYCLES), .WD_CYCLES(WD_CYCLES)) chk_u (.*);

// *** sim/svrw_host_model.sv ***
/* Host model: toggles the kick line every 10 cycles.
   Assumes the bench clock and the reset output. */
`timescale 1ns/100ps
module svrw_host_model (
    // Inputs
    input  wire logic sys_clk,
    input  wire logic kick_en,
    input  wire logic reset_out_n,
    // Kick line
    output logic      watchdog_kick = 1'h0
);
    // ========
    // Kicks only while enabled and out of reset
    int n = 0;
    always @(negedge sys_clk) begin
        n = (kick_en && reset_out_n) ? n % 10 + 1 : 0;
        if (n == 10) watchdog_kick <= ~watchdog_kick;
    end
endmodule : svrw_host_model

// *** sim/test_supervisor_reset_watchdog.sv ***
/* Bench for the supervisor block with a kicking host.
   Assumes package, design, host and checker compile first. */
`timescale 1ns/100ps
module test_supervisor_reset_watchdog;
    import svrw_pkg::*;
    localparam int RC = 20, WC = 50;
    logic sys_clk = 1'h0, reset_n = 1'h0, undervoltage = 1'h0, kick_en = 1'h1;
    logic power_fail_sense = 1'h1, manual_reset_request_n = 1'h1, watchdog_kick_float = 1'h0;
    logic watchdog_kick, reset_out_n, reset_out, watchdog_expired_n, power_fail_flag_n;
    int mismatches = 0, n_checks = 0, cyc = 0, n;
    always #50 sys_clk = ~sys_clk;
    svrw_top #(.RESET_CYCLES(RC), .WD_CYCLES(WC)) dut_u (.*);
    svrw_host_model host_u (.*);
    // ========
    // Tasks
    task automatic chk(string nm, logic e, logic g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %b got %b", nm, e, g);
        end
    endtask : chk
    task automatic wl(ref logic s, input logic v);
        for (n = 0; s !== v && n < 500; n++) @(negedge sys_clk);
    endtask : wl
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    always @(posedge sys_clk) if (++cyc == 3000) begin
        mismatches++;
        end_sim();
    end
    initial begin
        void'($urandom(32'h6241));
        repeat (2) @(negedge sys_clk);
        reset_n = 1'h1;
        wl(reset_out_n, 1'h1);
        chk("por", 1'h1, n inside {[RC:RC + 8]});
        chk("hi", 1'h0, reset_out);
        repeat (6) begin
            power_fail_sense = 1'($urandom);
            repeat (8) @(negedge sys_clk);
            chk("pf", power_fail_sense, power_fail_flag_n);
        end
        chk("kick", 1'h1, watchdog_expired_n);
        @(watchdog_kick);
        kick_en = 1'h0;
        wl(watchdog_expired_n, 1'h0);
        chk("wd", 1'h1, n inside {[WC:WC + 8]});
        repeat (20) @(negedge sys_clk);
        chk("wdo", 1'h0, watchdog_expired_n);
        chk("nor", 1'h1, reset_out_n);
        kick_en = 1'h1;
        wl(watchdog_expired_n, 1'h1);
        chk("clr", 1'h1, n inside {[10:18]});
        kick_en = 1'h0;
        watchdog_kick_float = 1'h1;
        repeat (3 * WC) @(negedge sys_clk);
        chk("flt", 1'h1, watchdog_expired_n);
        watchdog_kick_float = 1'h0;
        kick_en = 1'h1;
        // Bouncing manual request
        for (int i = 0; i < 6; i++) begin
            manual_reset_request_n = i[0];
            repeat (i[0] ? 1 + $urandom % 3 : 5) @(negedge sys_clk);
        end
        chk("mr", 1'h0, reset_out_n);
        wl(reset_out_n, 1'h1);
        chk("mrl", 1'h1, n inside {[RC:RC + 8]});
        undervoltage = 1'h1;
        repeat (2 * RC) @(negedge sys_clk);
        chk("uv", 1'h0, reset_out_n);
        chk("uvw", 1'h0, watchdog_expired_n);
        undervoltage = 1'h0;
        wl(watchdog_expired_n, 1'h1);
        chk("uvr", 1'h1, n inside {[1:8]});
        end_sim();
    end
endmodule : test_supervisor_reset_watchdog
